// ### pkg/uart_flow_pkg.sv
// Shared constants and types for the enhanced UART channel
package uart_flow_pkg;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] LAST_TICK = 4'hF;
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [4:0] IR_STRETCH_TICKS = 5'h10;
  localparam logic [7:0] CHAR_RESET = 8'h00;
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
  localparam logic [1:0] STRAP_DONE_CNT = 2'h3;
  localparam logic [3:0] MIN_DATA_BITS = 4'h5;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;
  localparam int TAG_W = 3;
  localparam int ENTRY_W = DATA_W + TAG_W;
  localparam int TAG_PAR = 0;
  localparam int TAG_FRM = 1;
  localparam int TAG_BRK = 2;
  localparam logic [4:0] TRIG_LVL [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  localparam logic [4:0] RESUME_LVL [4] = '{5'h00, 5'h01, 5'h04, 5'h08};
  typedef enum logic {TX_IDLE, TX_SEND} tx_st_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_st_e;
endpackage

// ### src/rx_fifo.sv
// Receive FIFO holding data byte and error tags per entry
`timescale 1ns/100ps
`default_nettype none
module rx_fifo #(
  parameter int WIDTH = uart_flow_pkg::ENTRY_W,
  parameter int DEPTH = uart_flow_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  output logic [$clog2(DEPTH):0] count,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rx_fifo depth must be a power of two of at least 2");
  end
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;
  fifo_s s_r, s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push, do_pop;

  assign empty = (s_r.cnt == '0);
  assign full = (s_r.cnt == (AW+1)'(DEPTH));
  assign do_push = push & !full;
  assign do_pop = pop & !empty;
  assign head_data = mem[s_r.rp];
  assign count = s_r.cnt;

  always_comb begin
    s_nxt = s_r;
    if (do_push) s_nxt.wp = s_r.wp + 1'b1;
    if (do_pop) s_nxt.rp = s_r.rp + 1'b1;
    if (do_push & !do_pop) s_nxt.cnt = s_r.cnt + 1'b1;
    else if (do_pop & !do_push) s_nxt.cnt = s_r.cnt - 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) s_r <= '0;
    else s_r <= s_nxt;
    if (do_push) mem[s_r.wp] <= push_data;
  end
endmodule // rx_fifo
`default_nettype wire

// ### src/ir_codec.sv
// Infrared pulse encoder and decoder
`timescale 1ns/100ps
`default_nettype none
module ir_codec (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic baud_tick,
  input wire logic ir_en,
  input wire logic ir_inv,
  input wire logic tx_bit,
  input wire logic tx_active,
  input wire logic [3:0] tx_phase,
  input wire logic rx_raw,
  output logic tx_out,
  output logic rx_bit
);
  typedef struct packed {
    logic tx_out;
    logic [4:0] stretch;
  } ir_s;
  ir_s s_r, s_nxt;
  logic pulse;

  assign pulse = ir_inv ? !rx_raw : rx_raw;
  assign rx_bit = ir_en ? !(pulse || s_r.stretch != '0) : rx_raw;
  assign tx_out = s_r.tx_out;

  always_comb begin
    s_nxt = s_r;
    if (ir_en) begin
      s_nxt.tx_out = tx_active & !tx_bit & (tx_phase < uart_flow_pkg::IR_PULSE_TICKS);
    end else begin
      s_nxt.tx_out = tx_bit;
    end
    if (ir_en & pulse) s_nxt.stretch = uart_flow_pkg::IR_STRETCH_TICKS;
    else if (baud_tick && s_r.stretch != '0) s_nxt.stretch = s_r.stretch - 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) s_r <= '{tx_out: 1'b1, stretch: 5'h00};
    else s_r <= s_nxt;
  end
endmodule // ir_codec
`default_nettype wire

// ### src/uart_flow_addr_infrared.sv
// UART channel with in-band flow control, address detect, direction control and infrared
`timescale 1ns/100ps
`default_nettype none
module uart_flow_addr_infrared (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic baud_tick,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic infrared_startup_pin,
  input wire logic [1:0] word_len,
  input wire logic [2:0] parity_cfg,
  input wire logic rx_flow_en,
  input wire logic tx_auto_flow_en,
  input wire logic flow_double,
  input wire logic special_det_en,
  input wire logic multidrop_en,
  input wire logic rx_enable,
  input wire logic hdx_en,
  input wire logic [3:0] hdx_delay,
  input wire logic ir_inv,
  input wire logic ir_mode_wr,
  input wire logic ir_mode_wdata,
  input wire logic [1:0] rx_trig_sel,
  input wire logic halt_int_en,
  input wire logic flag_clr,
  input wire logic char_wr,
  input wire logic [1:0] char_sel,
  input wire logic [7:0] char_wdata,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic rx_rd,
  output logic [7:0] rx_data,
  output logic [2:0] rx_tags,
  output logic rx_avail,
  output logic [4:0] rx_count,
  output logic lsr_int,
  output logic tx_empty_int,
  output logic halt_flag,
  output logic irq,
  output logic tx_halted,
  output logic dir_out,
  output logic ir_mode,
  output logic addr_rx_en
);
  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic st_s1;
    logic st_s2;
    logic [1:0] st_cnt;
    logic ir_mode;
    logic [7:0] halt_c1;
    logic [7:0] halt_c2;
    logic [7:0] res_c1;
    logic [7:0] res_c2;
    uart_flow_pkg::tx_st_e tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_tick;
    logic hold_v;
    logic [7:0] hold_d;
    logic halted;
    logic [1:0] ctl_left;
    logic ctl_res;
    logic ctl_idx;
    logic halt_sent;
    logic fl_run;
    logic [8:0] fl_tmr;
    logic dir;
    logic dly_run;
    logic [7:0] dly;
    uart_flow_pkg::rx_st_e rx_st;
    logic [3:0] rx_tick;
    logic [3:0] rx_left;
    logic [9:0] rx_sh;
    logic rx_en;
    logic pv;
    logic pv_res;
    logic [7:0] pv_c;
    logic rp_v;
    logic [10:0] rp_d;
    logic flag;
  } chan_s;
  chan_s s_r, s_nxt;

  logic line, ir_tx, fifo_empty, fifo_full, push;
  logic [10:0] push_data, head;
  logic [4:0] cnt;
  logic tx_busy;

  ir_codec u_ir (
    .sys_clk(sys_clk),
    .srst(srst),
    .baud_tick(baud_tick),
    .ir_en(s_r.ir_mode),
    .ir_inv(ir_inv),
    .tx_bit(tx_busy ? s_r.tx_sh[0] : 1'b1),
    .tx_active(tx_busy),
    .tx_phase(s_r.tx_tick),
    .rx_raw(s_r.rx_s2),
    .tx_out(ir_tx),
    .rx_bit(line)
  );

  rx_fifo u_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .push(push),
    .push_data(push_data),
    .pop(rx_rd),
    .head_data(head),
    .count(cnt),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  function automatic logic par_of(input logic [7:0] d, input logic [2:0] cfg);
    if (cfg[2]) par_of = !cfg[1];
    else par_of = cfg[1] ? ^d : !(^d);
  endfunction

  assign tx_busy = (s_r.tx_st == uart_flow_pkg::TX_SEND);
  assign tx_pin = ir_tx;
  assign tx_ready = !s_r.hold_v;
  assign rx_data = head[7:0];
  assign rx_tags = head[10:8];
  assign rx_avail = !fifo_empty;
  assign rx_count = cnt;
  assign lsr_int = !fifo_empty & (|head[10:8]);
  assign tx_empty_int = hdx_en ? (!s_r.hold_v & !tx_busy & s_r.ctl_left == 2'h0)
                               : !s_r.hold_v;
  assign halt_flag = s_r.flag;
  assign irq = s_r.flag & halt_int_en;
  assign tx_halted = s_r.halted;
  assign dir_out = s_r.dir;
  assign ir_mode = s_r.ir_mode;
  assign addr_rx_en = s_r.rx_en;

  always_comb begin
    logic [3:0] nb, fb;
    logic [7:0] mask, d, c, char_ticks;
    logic [10:0] fr;
    logic [9:0] rsh, rf;
    logic [2:0] tag;
    logic pb, stop, done, want, m_h1, m_h2, m_r1, m_r2, act, act_res, take;
    nb = uart_flow_pkg::MIN_DATA_BITS + {2'h0, word_len};
    fb = nb + {3'h0, parity_cfg[0]} + 4'h2;
    mask = 8'hFF >> (2'h3 - word_len);
    char_ticks = {fb, 4'h0};
    d = 8'h00;
    c = 8'h00;
    fr = 11'h7FF;
    rsh = 10'h000;
    rf = 10'h000;
    tag = 3'h0;
    pb = 1'b0;
    stop = 1'b1;
    done = 1'b0;
    act = 1'b0;
    act_res = 1'b0;
    take = 1'b0;
    push = 1'b0;
    push_data = 11'h000;
    s_nxt = s_r;
    s_nxt.rx_s1 = rx_pin;
    s_nxt.rx_s2 = s_r.rx_s1;
    s_nxt.st_s1 = infrared_startup_pin;
    s_nxt.st_s2 = s_r.st_s1;
    if (s_r.st_cnt != uart_flow_pkg::STRAP_DONE_CNT) begin
      s_nxt.st_cnt = s_r.st_cnt + 2'h1;
      if (s_r.st_cnt == uart_flow_pkg::STRAP_LOAD_CNT) s_nxt.ir_mode = s_r.st_s2;
    end else if (ir_mode_wr) begin
      s_nxt.ir_mode = ir_mode_wdata;
    end
    if (char_wr) begin
      case (char_sel)
        2'h0: s_nxt.res_c1 = char_wdata;
        2'h1: s_nxt.res_c2 = char_wdata;
        2'h2: s_nxt.halt_c1 = char_wdata;
        default: s_nxt.halt_c2 = char_wdata;
      endcase
    end
    // Transmitter
    want = (s_r.ctl_left != 2'h0) | (s_r.hold_v & !s_r.halted);
    case (s_r.tx_st)
      uart_flow_pkg::TX_IDLE: begin
        if (want && hdx_en && !s_r.dir) begin
          s_nxt.dir = 1'b1;
        end else if (want && baud_tick) begin
          if (s_r.ctl_left != 2'h0) begin
            case ({s_r.ctl_res, s_r.ctl_idx})
              2'b00: d = s_r.halt_c1;
              2'b01: d = s_r.halt_c2;
              2'b10: d = s_r.res_c1;
              default: d = s_r.res_c2;
            endcase
            s_nxt.ctl_left = s_r.ctl_left - 2'h1;
            s_nxt.ctl_idx = !s_r.ctl_idx;
          end else begin
            d = s_r.hold_d;
            s_nxt.hold_v = 1'b0;
          end
          d = d & mask;
          fr[0] = 1'b0;
          for (int i = 0; i < 8; i++) begin
            if (4'(i) < nb) fr[i+1] = d[i];
          end
          if (parity_cfg[0]) fr[nb+4'h1] = par_of(d, parity_cfg);
          s_nxt.tx_sh = fr;
          s_nxt.tx_left = fb;
          s_nxt.tx_tick = 4'h0;
          s_nxt.dly_run = 1'b0;
          s_nxt.tx_st = uart_flow_pkg::TX_SEND;
        end
      end
      uart_flow_pkg::TX_SEND: begin
        if (baud_tick) begin
          s_nxt.tx_tick = s_r.tx_tick + 4'h1;
          if (s_r.tx_tick == uart_flow_pkg::LAST_TICK) begin
            s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
            s_nxt.tx_left = s_r.tx_left - 4'h1;
            if (s_r.tx_left == 4'h1) begin
              s_nxt.tx_st = uart_flow_pkg::TX_IDLE;
              s_nxt.dly_run = hdx_en;
              s_nxt.dly = {hdx_delay, 4'h0};
            end
          end
        end
      end
      default: s_nxt.tx_st = uart_flow_pkg::TX_IDLE;
    endcase
    if (!hdx_en) begin
      s_nxt.dir = 1'b0;
    end else if (s_r.dly_run && !tx_busy) begin
      if (s_r.dly == 8'h00) begin
        s_nxt.dir = 1'b0;
        s_nxt.dly_run = 1'b0;
      end else if (baud_tick) begin
        s_nxt.dly = s_r.dly - 8'h01;
      end
    end
    if (tx_valid && !s_r.hold_v) begin
      s_nxt.hold_v = 1'b1;
      s_nxt.hold_d = tx_data;
    end
    // Receiver
    case (s_r.rx_st)
      uart_flow_pkg::RX_IDLE: begin
        if (baud_tick && !line && !(s_r.ir_mode && tx_busy)) begin
          s_nxt.rx_st = uart_flow_pkg::RX_START;
          s_nxt.rx_tick = 4'h0;
        end
      end
      uart_flow_pkg::RX_START: begin
        if (baud_tick) begin
          s_nxt.rx_tick = s_r.rx_tick + 4'h1;
          if (s_r.rx_tick == uart_flow_pkg::MID_TICK) begin
            s_nxt.rx_tick = 4'h0;
            s_nxt.rx_left = fb - 4'h1;
            s_nxt.rx_sh = 10'h000;
            s_nxt.rx_st = line ? uart_flow_pkg::RX_IDLE : uart_flow_pkg::RX_BITS;
          end
        end
      end
      uart_flow_pkg::RX_BITS: begin
        if (baud_tick) begin
          s_nxt.rx_tick = s_r.rx_tick + 4'h1;
          if (s_r.rx_tick == uart_flow_pkg::LAST_TICK) begin
            rsh = {line, s_r.rx_sh[9:1]};
            s_nxt.rx_sh = rsh;
            s_nxt.rx_left = s_r.rx_left - 4'h1;
            if (s_r.rx_left == 4'h1) begin
              done = 1'b1;
              s_nxt.rx_st = uart_flow_pkg::RX_IDLE;
            end
          end
        end
      end
      default: s_nxt.rx_st = uart_flow_pkg::RX_IDLE;
    endcase
    rf = rsh >> (4'hA - (fb - 4'h1));
    c = rf[7:0] & mask;
    pb = rf[nb];
    stop = rf[fb - 4'h2];
    tag[uart_flow_pkg::TAG_PAR] = parity_cfg[0] & (pb != par_of(c, parity_cfg));
    tag[uart_flow_pkg::TAG_FRM] = !stop;
    tag[uart_flow_pkg::TAG_BRK] = (rf == 10'h000);
    m_h1 = ((c ^ s_r.halt_c1) & mask) == 8'h00;
    m_h2 = ((c ^ s_r.halt_c2) & mask) == 8'h00;
    m_r1 = ((c ^ s_r.res_c1) & mask) == 8'h00;
    m_r2 = ((c ^ s_r.res_c2) & mask) == 8'h00;
    if (flag_clr) s_nxt.flag = 1'b0;
    if (s_r.rp_v) begin
      push = 1'b1;
      push_data = s_r.rp_d;
      s_nxt.rp_v = 1'b0;
    end
    if (done) begin
      if (multidrop_en && special_det_en) begin
        if (pb) begin
          s_nxt.rx_en = m_h2;
          take = m_h2;
          tag[uart_flow_pkg::TAG_PAR] = pb;
        end else begin
          take = s_r.rx_en;
        end
      end else if (multidrop_en) begin
        take = rx_enable | pb;
      end else if (rx_flow_en && flow_double && s_r.pv) begin
        s_nxt.pv = 1'b0;
        if (s_r.pv_res ? m_r2 : m_h2) begin
          act = 1'b1;
          act_res = s_r.pv_res;
        end else begin
          push = 1'b1;
          push_data = {3'h0, s_r.pv_c};
          if (m_h1 | m_r1) begin
            s_nxt.pv = 1'b1;
            s_nxt.pv_c = c;
            s_nxt.pv_res = !m_h1;
          end else begin
            s_nxt.rp_v = 1'b1;
            s_nxt.rp_d = {tag, c};
          end
        end
      end else if (rx_flow_en && flow_double && (m_h1 | m_r1)) begin
        s_nxt.pv = 1'b1;
        s_nxt.pv_c = c;
        s_nxt.pv_res = !m_h1;
      end else if (rx_flow_en && (m_h1 | m_r1)) begin
        act = 1'b1;
        act_res = !m_h1;
      end else begin
        take = 1'b1;
        if (special_det_en && m_h2) s_nxt.flag = 1'b1;
      end
      if (take) begin
        push = 1'b1;
        push_data = {tag, c};
      end
    end
    if (act && !act_res) begin
      s_nxt.halted = 1'b1;
      s_nxt.flag = 1'b1;
    end else if (act && s_r.halted) begin
      s_nxt.halted = 1'b0;
      s_nxt.flag = 1'b0;
    end
    if (!rx_flow_en) s_nxt.halted = 1'b0;
    // Automatic halt and resume sending
    if (!tx_auto_flow_en) begin
      s_nxt.fl_run = 1'b0;
      s_nxt.halt_sent = 1'b0;
    end else if (s_r.fl_run) begin
      if (s_r.fl_tmr == 9'h000 && s_r.ctl_left == 2'h0) begin
        s_nxt.fl_run = 1'b0;
        s_nxt.halt_sent = 1'b1;
        s_nxt.ctl_left = flow_double ? 2'h2 : 2'h1;
        s_nxt.ctl_res = 1'b0;
        s_nxt.ctl_idx = 1'b0;
      end else if (baud_tick && s_r.fl_tmr != 9'h000) begin
        s_nxt.fl_tmr = s_r.fl_tmr - 9'h001;
      end
    end else if (!s_r.halt_sent && cnt >= uart_flow_pkg::TRIG_LVL[rx_trig_sel]) begin
      s_nxt.fl_run = 1'b1;
      s_nxt.fl_tmr = {char_ticks, 1'b0};
    end else if (s_r.halt_sent && s_r.ctl_left == 2'h0
                 && cnt <= uart_flow_pkg::RESUME_LVL[rx_trig_sel]) begin
      s_nxt.halt_sent = 1'b0;
      s_nxt.ctl_left = flow_double ? 2'h2 : 2'h1;
      s_nxt.ctl_res = 1'b1;
      s_nxt.ctl_idx = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.halt_c1 <= uart_flow_pkg::CHAR_RESET;
      s_r.halt_c2 <= uart_flow_pkg::CHAR_RESET;
      s_r.res_c1 <= uart_flow_pkg::CHAR_RESET;
      s_r.res_c2 <= uart_flow_pkg::CHAR_RESET;
      s_r.tx_st <= uart_flow_pkg::TX_IDLE;
      s_r.rx_st <= uart_flow_pkg::RX_IDLE;
      s_r.tx_sh <= 11'h7FF;
      s_r.rx_s1 <= 1'b1;
      s_r.rx_s2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // uart_flow_addr_infrared
`default_nettype wire

// ### testbench/uart_flow_properties.sv
// Checker for flow, direction, infrared and receive status outputs
`timescale 1ns/100ps
`default_nettype none
module uart_flow_properties (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic baud_tick,
  input wire logic tx_pin,
  input wire logic special_det_en,
  input wire logic hdx_en,
  input wire logic [3:0] hdx_delay,
  input wire logic halt_int_en,
  input wire logic tx_ready,
  input wire logic [2:0] rx_tags,
  input wire logic rx_avail,
  input wire logic [4:0] rx_count,
  input wire logic lsr_int,
  input wire logic tx_empty_int,
  input wire logic halt_flag,
  input wire logic irq,
  input wire logic tx_halted,
  input wire logic dir_out,
  input wire logic ir_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Ticks seen while the transmit line is high
  logic [9:0] hi_r;
  logic [9:0] hi_nxt;
  always_comb begin
    hi_nxt = 10'h000;
    if (tx_pin) hi_nxt = hi_r + {9'h000, baud_tick & ~&hi_r};
  end
  always_ff @(posedge sys_clk) begin
    hi_r <= srst ? 10'h000 : hi_nxt;
  end
  irq_gate_a: assert property (irq == (halt_flag & halt_int_en))
    else $error("irq does not follow halt flag and enable");
  halt_flag_a: assert property ($rose(tx_halted) |-> halt_flag)
    else $error("halt without halt flag");
  resume_clear_a: assert property ($fell(tx_halted) && !special_det_en |-> !halt_flag)
    else $error("resume left halt flag set");
  ir_pulse_a: assert property ($fell(tx_pin) && ir_mode && $past(ir_mode, 2) |-> hi_r == 10'h003)
    else $error("infrared pulse width wrong");
  dir_first_a: assert property (hdx_en && !ir_mode && $fell(tx_pin) |-> dir_out)
    else $error("frame started with direction low");
  dir_hold_a: assert property (hdx_en && !ir_mode && $fell(dir_out)
    |-> hi_r >= {2'h0, hdx_delay, 4'h0} + 10'h00F)
    else $error("direction dropped before turnaround delay");
  empty_hdx_a: assert property (hdx_en && !ir_mode && !tx_pin |-> !tx_empty_int)
    else $error("empty reported while shifter busy");
  empty_plain_a: assert property (!hdx_en |-> tx_empty_int == tx_ready)
    else $error("empty does not follow holding register");
  lsr_tag_a: assert property (lsr_int == (rx_avail && (rx_tags != 3'h0)))
    else $error("line status interrupt does not follow head tags");
  avail_cnt_a: assert property (rx_avail == (rx_count != 5'h00))
    else $error("available flag does not follow count");
  cover property ($rose(tx_halted));
  cover property ($fell(dir_out));
  cover property ($fell(tx_pin) && ir_mode);
  cover property ($rose(lsr_int));
endmodule // uart_flow_properties
bind uart_flow_addr_infrared uart_flow_properties uart_flow_properties_i (.*);
`default_nettype wire

// ### testbench/remote_uart.sv
// Remote station: drives the receive line, decodes the transmit line when ir_sel is low
`timescale 1ns/100ps
`default_nettype none
module remote_uart #(
  parameter int BIT_CYC = 32
) (
  input wire logic sys_clk,
  input wire logic tx_pin,
  input wire logic ir_sel,
  output logic rx_pin
);
  logic [7:0] got [$];
  logic [7:0] sh;
  initial rx_pin = 1'b1;
  task automatic idle(input logic v);
    rx_pin <= v;
  endtask
  // Start, data LSB first, optional parity, one stop
  task automatic send(input logic [7:0] b, input int nb, input logic pe, input logic pv,
                      input logic ir, input logic inv);
    logic [10:0] f;
    int n;
    f = 11'h7FF;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i+1] = b[i];
    if (pe) f[nb+1] = pv;
    n = nb + (pe ? 3 : 2);
    for (int i = 0; i < n; i++) begin
      rx_pin <= ir ? inv ^ ~f[i] : f[i];
      repeat (6) @(posedge sys_clk);
      rx_pin <= ir ? inv : f[i];
      repeat (BIT_CYC - 6) @(posedge sys_clk);
    end
  endtask
  initial begin
    forever begin
      @(negedge tx_pin);
      if (!ir_sel) begin
        repeat (BIT_CYC / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge sys_clk);
          sh[i] = tx_pin;
        end
        repeat (BIT_CYC) @(posedge sys_clk);
        if (tx_pin) got.push_back(sh);
      end
    end
  end
endmodule // remote_uart
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the enhanced UART channel
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int BC = 32;
  localparam int FR = 10 * BC;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic baud_tick = 1'b0;
  logic rx_pin, infrared_startup_pin, rx_flow_en, tx_auto_flow_en, flow_double;
  logic special_det_en, multidrop_en, rx_enable, hdx_en, ir_inv, ir_mode_wr, ir_mode_wdata;
  logic halt_int_en, flag_clr, char_wr, tx_valid, rx_rd;
  logic [1:0] word_len, rx_trig_sel, char_sel;
  logic [2:0] parity_cfg, rx_tags;
  logic [3:0] hdx_delay;
  logic [4:0] rx_count;
  logic [7:0] char_wdata, tx_data, rx_data;
  logic tx_pin, tx_ready, rx_avail, lsr_int, tx_empty_int, halt_flag, irq, tx_halted;
  logic dir_out, ir_mode, addr_rx_en;
  int err_total = 0;
  int n_checks = 0;
  int seed = 32'hBAFA;
  uart_flow_addr_infrared uart_flow_addr_infrared_i (.*);
  remote_uart remote_uart_i (.sys_clk(sys_clk), .tx_pin(tx_pin), .ir_sel(ir_mode),
                             .rx_pin(rx_pin));
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) baud_tick <= ~baud_tick;
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic ir);
    infrared_startup_pin = ir;
    srst = 1'b1;
    cyc(5);
    srst = 1'b0;
    cyc(4);
  endtask
  task automatic wchar(input logic [1:0] s, input logic [7:0] v);
    char_sel = s;
    char_wdata = v;
    char_wr = 1'b1;
    cyc(1);
    char_wr = 1'b0;
    cyc(1);
  endtask
  task automatic put(input logic [7:0] b);
    for (int i = 0; i < 4000 && tx_ready !== 1'b1; i++) cyc(1);
    tx_data = b;
    tx_valid = 1'b1;
    cyc(1);
    tx_valid = 1'b0;
  endtask
  task automatic rd;
    rx_rd = 1'b1;
    cyc(1);
    rx_rd = 1'b0;
    cyc(1);
  endtask
  task automatic pop(input logic [10:0] e);
    chk("rx head", e, {rx_tags, rx_data});
    rd;
  endtask
  task automatic drain;
    while (rx_avail === 1'b1) rd;
  endtask
  task automatic rsend(input logic [7:0] b, input logic pv);
    remote_uart_i.send(b, int'(word_len) + 5, parity_cfg[0], pv, ir_mode, ir_inv);
    cyc(4);
  endtask
  function automatic logic [10:0] sent(input int i);
    return (remote_uart_i.got.size() > i) ? {3'h0, remote_uart_i.got[i]} : 11'h7FF;
  endfunction
  initial begin
    #8000000;
    err_total++;
    end_sim;
  end
  initial begin
    logic [7:0] h, r, x, a, t;
    int n;
    logic p;
    {infrared_startup_pin, rx_flow_en, tx_auto_flow_en, flow_double, special_det_en,
     multidrop_en, rx_enable, hdx_en, ir_inv, ir_mode_wr, ir_mode_wdata, halt_int_en,
     flag_clr, char_wr, tx_valid, rx_rd, rx_trig_sel, char_sel, parity_cfg, hdx_delay,
     char_wdata, tx_data} = '0;
    word_len = 2'h3;
    do_reset(1'b0);
    special_det_en = 1'b1;
    rsend(8'h00, 1'b0);
    chk("zero char match", 11'h001, {10'h000, halt_flag});
    pop(11'h000);
    flag_clr = 1'b1;
    cyc(1);
    flag_clr = 1'b0;
    word_len = 2'h0;
    wchar(2'h3, 8'hF5);
    rsend(8'h14, 1'b0);
    chk("no special", 11'h000, {10'h000, halt_flag});
    rsend(8'h15, 1'b0);
    chk("special short word", 11'h001, {10'h000, halt_flag});
    pop(11'h014);
    pop(11'h015);
    special_det_en = 1'b0;
    word_len = 2'h3;
    do_reset(1'b0);
    rx_flow_en = 1'b1;
    halt_int_en = 1'b1;
    h = 8'($random(seed));
    r = h ^ 8'h5A;
    wchar(2'h2, h);
    wchar(2'h0, r);
    put(8'hA1);
    rsend(h, 1'b0);
    chk("halted", 11'h003, {9'h000, tx_halted, irq});
    chk("halt not stored", 11'h000, {6'h00, rx_count});
    put(8'h3C);
    cyc(3 * FR);
    chk("frame in flight", 11'h0A1, sent(0));
    chk("held while halted", 11'h7FF, sent(1));
    rsend(r, 1'b0);
    chk("resumed", 11'h000, {9'h000, tx_halted, halt_flag});
    cyc(2 * FR);
    chk("sent after resume", 11'h03C, sent(1));
    flow_double = 1'b1;
    x = h ^ 8'hF0;
    wchar(2'h3, h ^ 8'h0F);
    wchar(2'h1, r ^ 8'h0F);
    rsend(h, 1'b0);
    rsend(x, 1'b0);
    pop({3'h0, h});
    pop({3'h0, x});
    rsend(h, 1'b0);
    rsend(h ^ 8'h0F, 1'b0);
    chk("double halt", 11'h020, {5'h00, tx_halted, rx_count});
    rsend(r, 1'b0);
    rsend(r ^ 8'h0F, 1'b0);
    chk("double resume", 11'h000, {5'h00, tx_halted, rx_count});
    do_reset(1'b0);
    rx_flow_en = 1'b0;
    flow_double = 1'b0;
    tx_auto_flow_en = 1'b1;
    wchar(2'h2, h);
    wchar(2'h0, r);
    for (int s = 0; s < 4; s++) begin
      rx_trig_sel = s[1:0];
      remote_uart_i.got.delete();
      for (int i = 1; i < uart_flow_pkg::TRIG_LVL[s]; i++) rsend(8'($random(seed)), 1'b0);
      cyc(2 * FR);
      chk("no halt below trigger", 11'h7FF, sent(0));
      rsend(8'($random(seed)), 1'b0);
      cyc(600);
      chk("halt not early", 11'h7FF, sent(0));
      cyc(700);
      chk("halt sent", {3'h0, h}, sent(0));
      while (rx_count > uart_flow_pkg::RESUME_LVL[s] + 5'h01) rd;
      cyc(2 * FR);
      chk("no resume above level", 11'h7FF, sent(1));
      rd;
      cyc(2 * FR);
      chk("resume sent", {3'h0, r}, sent(1));
      chk("single halt", 11'h7FF, sent(2));
      drain;
    end
    do_reset(1'b0);
    tx_auto_flow_en = 1'b0;
    multidrop_en = 1'b1;
    parity_cfg = 3'h7;
    a = 8'($random(seed));
    t = 8'($random(seed));
    rsend(a ^ 8'h01, 1'b0);
    chk("data dropped", 11'h000, {6'h00, rx_count});
    rsend(a, 1'b1);
    chk("address irq", 11'h001, {10'h000, lsr_int});
    if (rx_data === a) rx_enable = 1'b1;
    pop({3'h1, a});
    rsend(t, 1'b0);
    pop({3'h0, t});
    rx_enable = 1'b0;
    special_det_en = 1'b1;
    wchar(2'h3, a);
    rsend(t, 1'b0);
    rsend(a ^ 8'h80, 1'b1);
    chk("auto drop", 11'h000, {6'h00, rx_count});
    rsend(a, 1'b1);
    chk("auto enable", 11'h001, {10'h000, addr_rx_en});
    pop({3'h1, a});
    rsend(t, 1'b0);
    pop({3'h0, t});
    rsend(a ^ 8'h80, 1'b1);
    chk("auto disable", 11'h000, {5'h00, addr_rx_en, rx_count});
    do_reset(1'b0);
    multidrop_en = 1'b0;
    special_det_en = 1'b0;
    parity_cfg = 3'h0;
    hdx_en = 1'b1;
    hdx_delay = 4'h2;
    remote_uart_i.got.delete();
    put(t);
    cyc(2);
    chk("direction up", 11'h002, {9'h000, dir_out, tx_empty_int});
    cyc(FR);
    chk("direction held", 11'h001, {10'h000, dir_out});
    cyc(3 * BC);
    chk("direction down", 11'h001, {9'h000, dir_out, tx_empty_int});
    chk("hdx byte", {3'h0, t}, sent(0));
    hdx_en = 1'b0;
    remote_uart_i.idle(1'b0);
    do_reset(1'b1);
    chk("ir strap", 11'h002, {9'h000, ir_mode, tx_pin});
    cyc(FR);
    drain;
    put(8'h55);
    n = 0;
    p = 1'b0;
    repeat (FR + 40) begin
      cyc(1);
      if (tx_pin && !p) n++;
      p = tx_pin;
    end
    chk("ir pulses", 11'h005, 11'(n));
    for (int v = 0; v < 2; v++) begin
      ir_inv = v[0];
      remote_uart_i.idle(v[0]);
      cyc(FR + 2 * BC);
      drain;
      t = 8'($random(seed));
      rsend(t, 1'b0);
      cyc(BC);
      pop({3'h0, t});
    end
    ir_mode_wdata = 1'b0;
    ir_mode_wr = 1'b1;
    cyc(1);
    ir_mode_wr = 1'b0;
    cyc(2);
    chk("ir overwrite", 11'h001, {9'h000, ir_mode, tx_pin});
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
